// ===== rtl/susp_consts.vh
// Opcodes, status values and timing constants of the suspend/resume controller
`ifndef SUSP_CONSTS_VH
`define SUSP_CONSTS_VH
`define OP_SUSPEND      8'h75
`define OP_RESUME       8'h7a
`define OP_READ_STATUS  8'h05
`define OP_WRITE_STATUS 8'h01
`define OP_PAGE_PROGRAM 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK32      8'h52
`define OP_BLOCK64      8'hd8
`define OP_CHIP_ERASE_A 8'hc7
`define OP_CHIP_ERASE_B 8'h60
`define STATUS_RESET    8'h00
`define ERASED_BYTE     8'hff
`define STATUS_BUSY_BIT 0
`define CLK_PERIOD_NS   50
`define SUSPEND_TIME_NS 2000
`define SUSPEND_CYCLES  (`SUSPEND_TIME_NS / `CLK_PERIOD_NS)
// Edges from select pin rising to the pausing state: two sync flops, framing, state
`define SUSPEND_LATENCY 4
`define SUSPEND_LAST    (`SUSPEND_CYCLES - `SUSPEND_LATENCY - 1)
`define PUW_MIN_TIME_US 1000
// One millisecond at 50 ns per cycle
`define PUW_MIN_CYCLES  16'd20000
`define OPCODE_BITS     4'd8
`endif

// ===== rtl/opcode_receiver.v
// Serial opcode receiver: synchronises the pins and frames one opcode per select
`include "susp_consts.vh"
`default_nettype none
module opcode_receiver (
    input  wire       ref_clk,      // System clock
    input  wire       reset_n,      // Asynchronous reset, active low
    input  wire       cs_n,         // Chip select pin, active low
    input  wire       sclk,         // Serial clock pin
    input  wire       si,           // Serial data in pin
    output reg        op_valid,     // One-cycle pulse: opcode framed
    output reg  [7:0] op_code       // Received opcode
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    reg  [2:0] meta_q;
    reg  [2:0] sync_q;
    reg        sclk_prev_q;
    reg        cs_prev_q;
    reg  [7:0] shift_q;
    reg  [3:0] count_q;
    wire       cs_n_s = sync_q[2];
    wire       sclk_s = sync_q[1];
    wire       si_s   = sync_q[0];

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            // Idle pin levels: select high, clock and data low
            meta_q <= 3'h4;
            sync_q <= 3'h4;
        end else begin
            meta_q <= {cs_n, sclk, si};
            sync_q <= meta_q;
        end
    end

    // ****************************************
    // Shift and frame
    // ****************************************
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_prev_q <= 1'b0;
            cs_prev_q   <= 1'b1;
            shift_q     <= 8'h00;
            count_q     <= 4'h0;
            op_valid    <= 1'b0;
            op_code     <= 8'h00;
        end else begin
            sclk_prev_q <= sclk_s;
            cs_prev_q   <= cs_n_s;
            op_valid    <= 1'b0;
            if (cs_n_s) begin
                count_q <= 4'h0;
                // Only exactly eight bits count as an opcode
                if (!cs_prev_q && count_q == `OPCODE_BITS) begin
                    op_valid <= 1'b1;
                    op_code  <= shift_q;
                end
            end else if (sclk_s && !sclk_prev_q) begin
                shift_q <= {shift_q[6:0], si_s};
                if (count_q != 4'h9)
                    count_q <= count_q + 4'h1;
            end
        end
    end
endmodule // opcode_receiver
`default_nettype wire

// ===== rtl/suspend_ctrl.v
// Program/erase suspend and resume controller with busy status and power-up lockout
// Operation
// - Opcode 75h pauses a running sector erase, block erase or page program.
// - While suspended, refuse status write, page program and all erase opcodes.
// - Suspend only acts during sector erase, block erase or page program.
// - Read-status stays usable while the suspend is taking effect.
// - Busy reads 1 during suspend transition, 0 once suspended.
// - Power loss (reset) clears any suspended state.
// - Opcode 7Ah continues the suspended operation to completion.
// - Accepted resume sets busy back to 1 for the rest of the operation.
// - Resume is ignored unless a suspension is active.
// - Array is delivered erased; every byte reads ffh.
// - Status register holds 00h after power-up.
// - Write instructions are rejected for the power-up lockout time.
// - Suspension completes within 2 us of select rising after opcode.
`include "susp_consts.vh"
`default_nettype none
module suspend_ctrl #(
    parameter [15:0] PUW_CYCLES = `PUW_MIN_CYCLES  // Power-up write lockout length
) (
    input  wire       ref_clk,        // 20 MHz system clock
    input  wire       reset_n,        // Power-on reset, active low
    input  wire       cs_n,           // Chip select pin, active low
    input  wire       sclk,           // Serial clock pin
    input  wire       si,             // Serial data in pin
    input  wire       op_done,        // Array engine finished current operation
    output reg  [7:0] status_q,       // Status register image
    output wire       busy,           // Busy flag
    output wire       suspended,      // Suspension complete and active
    output wire       engine_hold,    // Array engine must pause
    output reg        write_grant,    // Pulse: write opcode accepted
    output reg  [7:0] grant_code,     // Opcode that was granted
    output reg        cmd_refused,    // Pulse: write opcode refused
    output reg        status_read,    // Pulse: read-status opcode served
    output reg        write_lockout,  // Power-up write lockout active
    output wire [7:0] erased_value    // Value of an erased array byte
);
    // ****************************************
    // States
    // ****************************************
    localparam [1:0] ST_IDLE    = 2'h0;
    localparam [1:0] ST_RUN     = 2'h1;
    localparam [1:0] ST_PAUSING = 2'h2;
    localparam [1:0] ST_PAUSED  = 2'h3;
    localparam integer SUS_LAST_I  = `SUSPEND_LAST;
    localparam [5:0]   SUS_LAST    = SUS_LAST_I[5:0];
    localparam [7:0]   STATUS_INIT = `STATUS_RESET;
    localparam integer BUSY_BIT    = `STATUS_BUSY_BIT;

    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg         can_pause_q;
    reg  [5:0]  sus_cnt_q;
    reg  [15:0] puw_cnt_q;
    wire        op_valid;
    wire [7:0]  op_code;
    reg         is_write;
    reg         is_pausable;
    wire        pause_req;
    wire        resume_req;
    wire        read_req;
    wire [7:0]  status_d;
    genvar      gi;

    opcode_receiver u_rx (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .cs_n     (cs_n),
        .sclk     (sclk),
        .si       (si),
        .op_valid (op_valid),
        .op_code  (op_code)
    );

    assign erased_value = `ERASED_BYTE;

    // ****************************************
    // Opcode classes
    // ****************************************
    always @* begin
        is_write    = 1'b0;
        is_pausable = 1'b0;
        case (op_code)
            `OP_WRITE_STATUS, `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: is_write = 1'b1;
            `OP_PAGE_PROGRAM, `OP_SECTOR_ERASE, `OP_BLOCK32, `OP_BLOCK64: begin
                is_write    = 1'b1;
                is_pausable = 1'b1;
            end
            default: is_write = 1'b0;
        endcase
    end

    // ****************************************
    // Command decode
    // ****************************************
    // A suspend only counts while a pausable operation runs
    assign pause_req  = op_valid && (op_code == `OP_SUSPEND) && can_pause_q;
    assign resume_req = op_valid && (op_code == `OP_RESUME);
    assign read_req   = op_valid && (op_code == `OP_READ_STATUS);

    // ****************************************
    // Next state
    // ****************************************
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (op_valid && is_write && !write_lockout)
                    state_d = ST_RUN;
            end
            ST_RUN: begin
                // A finishing operation wins over a late suspend
                if (op_done)
                    state_d = ST_IDLE;
                else if (pause_req)
                    state_d = ST_PAUSING;
            end
            ST_PAUSING: begin
                if (sus_cnt_q == SUS_LAST)
                    state_d = ST_PAUSED;
            end
            ST_PAUSED: begin
                // The held engine cannot finish here; only a resume leaves
                if (resume_req)
                    state_d = ST_RUN;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // ****************************************
    // Power-up write lockout
    // ****************************************
    // Writes stay refused until the counter has run out once
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            puw_cnt_q     <= 16'h0000;
            write_lockout <= 1'b1;
        end else if (write_lockout) begin
            if (puw_cnt_q == PUW_CYCLES - 16'h0001)
                write_lockout <= 1'b0;
            puw_cnt_q <= puw_cnt_q + 16'h0001;
        end
    end

    // ****************************************
    // Suspend timer
    // ****************************************
    // Counts cycles spent pausing; cleared in every other state
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            sus_cnt_q <= 6'h00;
        else if (state_q == ST_PAUSING)
            sus_cnt_q <= sus_cnt_q + 6'h01;
        else
            sus_cnt_q <= 6'h00;
    end

    // ****************************************
    // Write grant and refusal
    // ****************************************
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            can_pause_q <= 1'b0;
            write_grant <= 1'b0;
            grant_code  <= 8'h00;
            cmd_refused <= 1'b0;
        end else begin
            write_grant <= 1'b0;
            cmd_refused <= 1'b0;
            if (op_valid && is_write) begin
                if (state_q == ST_IDLE && !write_lockout) begin
                    write_grant <= 1'b1;
                    grant_code  <= op_code;
                    can_pause_q <= is_pausable;
                end else begin
                    cmd_refused <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Read-status strobe
    // ****************************************
    // Served in every state, suspend transition included
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            status_read <= 1'b0;
        else
            status_read <= read_req;
    end

    // ****************************************
    // Status
    // ****************************************
    assign busy        = (state_q == ST_RUN) || (state_q == ST_PAUSING);
    assign suspended   = (state_q == ST_PAUSED);
    assign engine_hold = (state_q == ST_PAUSING) || (state_q == ST_PAUSED);

    // Only the busy bit is live; the others keep their delivered value
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_status
            if (gi == BUSY_BIT) begin : g_busy
                assign status_d[gi] = (state_d == ST_RUN) || (state_d == ST_PAUSING);
            end else begin : g_fixed
                assign status_d[gi] = STATUS_INIT[gi];
            end
        end
    endgenerate

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            status_q <= STATUS_INIT;
        else
            status_q <= status_d;
    end
endmodule // suspend_ctrl
`default_nettype wire

// ===== tb/spi_host_model.sv
// Host side model that frames single opcodes on the serial pins
`default_nettype none
module spi_host_model (
    input  wire logic ref_clk, // System clock
    output var  logic cs_n,    // Select, active low
    output var  logic sclk,    // Serial clock
    output var  logic si       // Serial data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si   = 1'b0;
    end
    task automatic half();
        repeat (4) @(negedge ref_clk);
    endtask
    // One opcode per select, MSB first; clock idles low outside frames
    task automatic send_op(input logic [7:0] op);
        cs_n = 1'b0;
        half();
        for (int i = 7; i >= 0; i--) begin
            si = op[i];
            half();
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
        half();
        cs_n = 1'b1;
        si   = ~si;
        repeat (11) half();
    endtask
endmodule // spi_host_model
`default_nettype wire

// ===== tb/susp_checker.sv
// Assertion checker for the suspend and resume controller
`default_nettype none
module susp_checker (
    input wire logic       ref_clk,       // Clock
    input wire logic       reset_n,       // Reset, active low
    input wire logic [7:0] status_q,      // Status image
    input wire logic       busy,          // Busy flag
    input wire logic       suspended,     // Suspended
    input wire logic       engine_hold,   // Engine pause
    input wire logic       write_grant,   // Grant pulse
    input wire logic       write_lockout  // Lockout level
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_status_image: assert property
        (status_q == {7'h00, busy}) else $error("status image wrong");
    a_suspend_time: assert property
        ($rose(engine_hold) |-> ##[1:37] (suspended && !busy)) else $error("suspend late");
    a_suspend_idle: assert property
        (suspended |-> (!busy && engine_hold)) else $error("suspended but busy");
    a_no_grant_susp: assert property
        (suspended |=> !write_grant) else $error("grant while suspended");
    a_lockout_grant: assert property
        (write_lockout |=> !write_grant) else $error("grant in lockout");
    a_hold_needs_run: assert property
        ($rose(engine_hold) |-> $past(busy) && !$past(suspended)) else $error("bad pause");
    a_resume_busy: assert property
        ($fell(suspended) |-> (busy && !engine_hold)) else $error("resume not busy");
    a_busy_cause: assert property
        ($rose(busy) |-> (write_grant || $past(suspended))) else $error("busy without cause");
endmodule // susp_checker
bind suspend_ctrl susp_checker u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .status_q(status_q), .busy(busy), .suspended(suspended), .engine_hold(engine_hold),
    .write_grant(write_grant), .write_lockout(write_lockout));
`default_nettype wire

// ===== tb/flash_program_erase_suspend_resume_tb.sv
// Self-checking bench for the suspend and resume controller
`default_nettype none
module flash_program_erase_suspend_resume_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PUW = 200;
    logic       ref_clk, reset_n, cs_n, sclk, si, op_done, busy, suspended, engine_hold;
    logic       write_grant, cmd_refused, status_read, write_lockout;
    logic [7:0] status_q, grant_code, erased_value;
    logic [7:0] wr_ops [7] = '{8'h01, 8'h02, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
    int         fails, tests_run, n_gr, n_rf, n_st;
    suspend_ctrl #(.PUW_CYCLES(16'(PUW))) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .cs_n(cs_n), .sclk(sclk), .si(si), .op_done(op_done), .status_q(status_q),
        .busy(busy), .suspended(suspended), .engine_hold(engine_hold),
        .write_grant(write_grant), .grant_code(grant_code), .cmd_refused(cmd_refused),
        .status_read(status_read), .write_lockout(write_lockout),
        .erased_value(erased_value));
    spi_host_model u_host (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .si(si));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Pulses stand one cycle, so count them as they pass
    always @(posedge ref_clk) begin
        if (write_grant) n_gr++;
        if (cmd_refused) n_rf++;
        if (status_read) n_st++;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic pausable(input logic [7:0] op);
        return op inside {8'h02, 8'h20, 8'h52, 8'hd8};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic op(input logic [7:0] c, input int g, input int r);
        int g0, r0;
        g0 = n_gr;
        r0 = n_rf;
        u_host.send_op(c);
        check(n_gr - g0, g);
        check(n_rf - r0, r);
    endtask
    task automatic done_pulse();
        op_done = 1'b1;
        @(negedge ref_clk);
        op_done = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic wait_susp();
        int k;
        for (k = 0; k < 60 && suspended !== 1'b1; k++) @(negedge ref_clk);
        if (k == 60) begin
            fails++;
            test_done();
        end
    endtask
    initial begin
        logic [31:0] rnd;
        logic [7:0]  c;
        int          s0;
        rnd = 32'h00011ea7;
        {fails, tests_run, n_gr, n_rf, n_st} = '0;
        op_done = 1'b0;
        reset_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        check(status_q, 8'h00);
        check(erased_value, 8'hff);
        reset_n = 1'b1;
        op(8'h02, 0, 1);
        repeat (PUW) @(negedge ref_clk);
        op(8'h7a, 0, 0);
        op(8'h75, 0, 0);
        check({busy, engine_hold}, 2'b00);
        for (int n = 0; n < 8; n++) begin
            rnd = lfsr(rnd);
            c = wr_ops[rnd % 7];
            op(c, 1, 0);
            check(grant_code, c);
            check(status_q, 8'h01);
            op(8'h75, 0, 0);
            check(engine_hold, pausable(c));
            if (pausable(c)) begin
                wait_susp();
                check(busy, 0);
                check(status_q, 8'h00);
                s0 = n_st;
                u_host.send_op(8'h05);
                check(n_st - s0, 1);
                done_pulse();
                check(suspended, 1);
                foreach (wr_ops[i]) op(wr_ops[i], 0, 1);
                op(8'h7a, 0, 0);
                check({busy, suspended, engine_hold}, 3'b100);
                check(status_q, 8'h01);
            end
            done_pulse();
            check(busy, 0);
        end
        op(8'h20, 1, 0);
        op(8'h75, 0, 0);
        wait_susp();
        reset_n = 1'b0;
        @(negedge ref_clk);
        reset_n = 1'b1;
        @(negedge ref_clk);
        check({suspended, engine_hold, busy, write_lockout}, 4'h1);
        test_done();
    end
endmodule // flash_program_erase_suspend_resume_tb
`default_nettype wire
